// ===== logic/tbl_skip_pkg.sv
// Overview of operation
// RULE1 - table pointer is 21 bits, byte addressed, spanning 2 Mbyte of program memory
// RULE2 - pointer bit 0 picks low byte (0) or high byte (1) of a word
// RULE3 - table read loads the addressed program byte into the latch, flags untouched
// RULE4 - table write copies latch into one of 8 holding registers by pointer bits 2:0
// RULE5 - holding registers are the staging data for later flash programming
// RULE6 - mode 0 keeps, 1 post-increments, 2 post-decrements, 3 pre-increments pointer
// RULE7 - skip-if-zero tests register; zero squashes next instruction, two cycles
// RULE8 - skipping a two-word instruction takes three cycles in total
// RULE9 - access bit 0 uses the access bank, 1 uses the bank select register
// RULE10 - access 0 with extended set uses indexed literal offset for addresses to 5Fh
// RULE11 - extended set enable is a configuration bit, enabled when unprogrammed
// RULE12 - table access takes two cycles, transfer in second, pointer updated before next
package tbl_skip_pkg;
  localparam int          PTR_W        = 21;
  localparam int          HOLD_N       = 8;
  localparam int          HOLD_SEL_W   = 3;
  localparam logic [15:0] TBL_MASK     = 16'hFFFC;
  localparam logic [15:0] TBL_RD_PAT   = 16'h0008;
  localparam logic [15:0] TBL_WR_PAT   = 16'h000C;
  localparam logic [15:0] SKIP_MASK    = 16'hFE00;
  localparam logic [15:0] SKIP_PAT     = 16'h6600;
  localparam int          SKIP_A_BIT   = 8;
  localparam logic [7:0]  ILO_LIMIT    = 8'h5F;
  localparam logic [7:0]  ACCESS_HI    = 8'h60;
  localparam logic [3:0]  ACC_BANK_HI  = 4'hF;
  localparam logic [1:0]  MODE_KEEP    = 2'h0;
  localparam logic [1:0]  MODE_POSTINC = 2'h1;
  localparam logic [1:0]  MODE_POSTDEC = 2'h2;
  localparam logic [1:0]  MODE_PREINC  = 2'h3;
  localparam logic        EXT_DEFAULT  = 1'h1;
  localparam logic [7:0]  HOLD_RESET   = 8'hFF;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_TABLE = 2'b01,
    ST_SKIP1 = 2'b10,
    ST_SKIP2 = 2'b11
  } state_t;
endpackage

// ===== logic/tbl_skip_exec.sv
`timescale 1ns/1ns
`default_nettype none
module tbl_skip_exec (
  input  wire logic        CLOCK_I,
  input  wire logic        RST_N_I,
  input  wire logic        INSTR_VALID_I,
  input  wire logic [15:0] INSTR_I,
  input  wire logic        NEXT_TWO_WORD_I,
  input  wire logic        EXT_SET_CFG_I,
  input  wire logic        CFG_LOAD_I,
  input  wire logic [3:0]  BANK_SELECT_I,
  input  wire logic [7:0]  FSR2_LOW_I,
  input  wire logic [7:0]  REG_DATA_I,
  input  wire logic [7:0]  PROG_BYTE_I,
  input  wire logic        PTR_WR_I,
  input  wire logic [20:0] PTR_WDATA_I,
  input  wire logic        LATCH_WR_I,
  input  wire logic [7:0]  LATCH_WDATA_I,
  output logic      [11:0] REG_ADDR_O,
  output logic      [20:0] PROG_ADDR_O,
  output logic             PROG_RD_O,
  output logic      [20:0] TABLE_POINTER_O,
  output logic      [7:0]  TABLE_LATCH_O,
  output logic      [63:0] HOLD_DATA_O,
  output logic             BUSY_O,
  output logic             SQUASH_O,
  output logic             EXT_SET_ENABLE_O
);
  localparam int P = tbl_skip_pkg::PTR_W;

  tbl_skip_pkg::state_t state_reg;
  logic [P-1:0] table_pointer_reg;
  logic [7:0]   table_latch_reg;
  logic [7:0]   hold_reg [tbl_skip_pkg::HOLD_N];
  logic         is_write_reg;
  logic [1:0]   mode_reg;
  logic         ext_set_reg;
  logic         cfg_seen_reg;
  logic         busy_reg;
  logic         squash_reg;
  logic         prog_rd_reg;
  logic [P-1:0] prog_addr_reg;
  logic [11:0]  reg_addr_reg;

  wire is_tbl  = INSTR_VALID_I && state_reg == tbl_skip_pkg::ST_IDLE
                 && (INSTR_I & tbl_skip_pkg::TBL_MASK) == tbl_skip_pkg::TBL_RD_PAT;
  wire is_tblw = INSTR_VALID_I && state_reg == tbl_skip_pkg::ST_IDLE
                 && (INSTR_I & tbl_skip_pkg::TBL_MASK) == tbl_skip_pkg::TBL_WR_PAT;
  wire is_skip = INSTR_VALID_I && state_reg == tbl_skip_pkg::ST_IDLE
                 && (INSTR_I & tbl_skip_pkg::SKIP_MASK) == tbl_skip_pkg::SKIP_PAT;
  wire [1:0] op_mode = INSTR_I[1:0];

  function automatic logic [P-1:0] ptr_step(input logic [P-1:0] p, input logic [1:0] m,
                                            input logic pre);
    logic [P-1:0] one;
    one = {{(P-1){1'b0}}, 1'b1};
    if (pre)
      ptr_step = (m == tbl_skip_pkg::MODE_PREINC) ? p + one : p;
    else if (m == tbl_skip_pkg::MODE_POSTINC)
      ptr_step = p + one;
    else if (m == tbl_skip_pkg::MODE_POSTDEC)
      ptr_step = p - one;
    else
      ptr_step = p;
  endfunction

  // register address: access bank, bank select, or indexed literal offset
  function automatic logic [11:0] file_addr(input logic [7:0] f, input logic a,
                                            input logic x, input logic [3:0] b,
                                            input logic [7:0] fsr2);
    if (a)
      file_addr = {b, f}; // RULE9
    else if (x && f <= tbl_skip_pkg::ILO_LIMIT)
      file_addr = {4'h0, 8'(fsr2 + f)}; // RULE10
    else if (f >= tbl_skip_pkg::ACCESS_HI)
      file_addr = {tbl_skip_pkg::ACC_BANK_HI, f}; // RULE9
    else
      file_addr = {4'h0, f};
  endfunction

  // configuration bit caught once after reset, defaulting to enabled
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ext_set_reg  <= tbl_skip_pkg::EXT_DEFAULT; // RULE11
      cfg_seen_reg <= 1'b0;
    end else if (CFG_LOAD_I && !cfg_seen_reg) begin
      ext_set_reg  <= EXT_SET_CFG_I; // RULE11
      cfg_seen_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_reg    <= tbl_skip_pkg::ST_IDLE;
      is_write_reg <= 1'b0;
      mode_reg     <= tbl_skip_pkg::MODE_KEEP;
      squash_reg   <= 1'b0;
    end else begin
      case (state_reg)
        tbl_skip_pkg::ST_IDLE: begin
          squash_reg <= 1'b0;
          if (is_tbl || is_tblw) begin
            state_reg    <= tbl_skip_pkg::ST_TABLE; // RULE12
            is_write_reg <= is_tblw;
            mode_reg     <= op_mode;
          end else if (is_skip && REG_DATA_I == 8'h00) begin
            state_reg  <= tbl_skip_pkg::ST_SKIP1; // RULE7
            squash_reg <= 1'b1;
          end
        end
        tbl_skip_pkg::ST_TABLE: state_reg <= tbl_skip_pkg::ST_IDLE;
        tbl_skip_pkg::ST_SKIP1: begin
          if (NEXT_TWO_WORD_I) begin
            state_reg <= tbl_skip_pkg::ST_SKIP2; // RULE8
          end else begin
            state_reg  <= tbl_skip_pkg::ST_IDLE;
            squash_reg <= 1'b0;
          end
        end
        tbl_skip_pkg::ST_SKIP2: begin
          state_reg  <= tbl_skip_pkg::ST_IDLE;
          squash_reg <= 1'b0;
        end
        default: state_reg <= tbl_skip_pkg::ST_IDLE;
      endcase
    end
  end

  // pre-increment applies in the decode cycle, post-step after the transfer
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      table_pointer_reg <= '0;
      prog_addr_reg     <= '0;
      prog_rd_reg       <= 1'b0;
    end else begin
      prog_rd_reg <= 1'b0;
      if (is_tbl || is_tblw) begin
        table_pointer_reg <= ptr_step(table_pointer_reg, op_mode, 1'b1); // RULE6
        prog_addr_reg     <= ptr_step(table_pointer_reg, op_mode, 1'b1); // RULE1
        prog_rd_reg       <= is_tbl;
      end else if (state_reg == tbl_skip_pkg::ST_TABLE) begin
        table_pointer_reg <= ptr_step(table_pointer_reg, mode_reg, 1'b0); // RULE6 RULE12
      end else if (PTR_WR_I) begin
        table_pointer_reg <= PTR_WDATA_I;
      end
    end
  end

  // the flash supplies the byte chosen by address bit 0 within its word
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      table_latch_reg <= 8'h00;
    end else if (state_reg == tbl_skip_pkg::ST_TABLE && !is_write_reg) begin
      table_latch_reg <= PROG_BYTE_I; // RULE3 RULE2
    end else if (LATCH_WR_I) begin
      table_latch_reg <= LATCH_WDATA_I;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      for (int i = 0; i < tbl_skip_pkg::HOLD_N; i++) begin
        hold_reg[i] <= tbl_skip_pkg::HOLD_RESET;
      end
    end else if (state_reg == tbl_skip_pkg::ST_TABLE && is_write_reg) begin
      hold_reg[prog_addr_reg[tbl_skip_pkg::HOLD_SEL_W-1:0]] <= table_latch_reg; // RULE4
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      reg_addr_reg <= 12'h000;
    end else if (INSTR_VALID_I) begin
      reg_addr_reg <= file_addr(INSTR_I[7:0], INSTR_I[tbl_skip_pkg::SKIP_A_BIT], ext_set_reg,
                                BANK_SELECT_I, FSR2_LOW_I);
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= is_tbl || is_tblw;
    end
  end

  // staging data for the flash programmer
  always_comb begin
    for (int i = 0; i < tbl_skip_pkg::HOLD_N; i++) begin
      HOLD_DATA_O[i*8 +: 8] = hold_reg[i]; // RULE5
    end
  end

  assign REG_ADDR_O       = reg_addr_reg;
  assign PROG_ADDR_O      = prog_addr_reg;
  assign PROG_RD_O        = prog_rd_reg;
  assign TABLE_POINTER_O  = table_pointer_reg;
  assign TABLE_LATCH_O    = table_latch_reg;
  assign BUSY_O           = busy_reg;
  assign SQUASH_O         = squash_reg;
  assign EXT_SET_ENABLE_O = ext_set_reg;

  sequence tbl_finish;
    state_reg == tbl_skip_pkg::ST_TABLE ##1 state_reg == tbl_skip_pkg::ST_IDLE;
  endsequence
  a_tbl_two_cycle: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RULE12
    (is_tbl || is_tblw) |=> tbl_finish)
    else $error("table access not two cycles");
  a_read_latch: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RULE3
    (state_reg == tbl_skip_pkg::ST_TABLE && !is_write_reg) |=>
      table_latch_reg == $past(PROG_BYTE_I))
    else $error("latch not loaded from program byte");
  a_write_no_read: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RULE4
    is_tblw |=> !prog_rd_reg)
    else $error("table write strobed a flash read");
  a_postinc_ptr: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RULE6
    ((is_tbl || is_tblw) && op_mode == tbl_skip_pkg::MODE_POSTINC) |=>
      ##1 table_pointer_reg == $past(table_pointer_reg, 2) + 21'h1)
    else $error("post-increment wrong");
  a_postdec_ptr: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RULE6
    ((is_tbl || is_tblw) && op_mode == tbl_skip_pkg::MODE_POSTDEC) |=>
      ##1 table_pointer_reg == $past(table_pointer_reg, 2) - 21'h1)
    else $error("post-decrement wrong");
  a_preinc_addr: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RULE6
    (is_tbl && op_mode == tbl_skip_pkg::MODE_PREINC) |=>
      prog_addr_reg == $past(table_pointer_reg) + 21'h1 && prog_rd_reg)
    else $error("pre-increment address wrong");
  a_hold_write: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RULE4
    (state_reg == tbl_skip_pkg::ST_TABLE && is_write_reg) |=>
      hold_reg[$past(prog_addr_reg[tbl_skip_pkg::HOLD_SEL_W-1:0])]
        == $past(table_latch_reg))
    else $error("holding register not written");
  sequence skip_start;
    is_skip && REG_DATA_I == 8'h00;
  endsequence
  a_skip_squash: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RULE7
    skip_start |=> squash_reg)
    else $error("zero did not squash");
  a_no_skip: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RULE7
    (is_skip && REG_DATA_I != 8'h00) |=> !squash_reg)
    else $error("nonzero squashed");
  a_skip_two_word: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RULE8
    skip_start ##1 NEXT_TWO_WORD_I |=> squash_reg ##1 !squash_reg)
    else $error("two-word skip length wrong");
endmodule
`default_nettype wire

// ===== testbench/prog_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
module prog_flash_model (
  input  wire logic        clk_i,
  input  wire logic        rd_i,
  input  wire logic [20:0] addr_i,
  output logic      [7:0]  byte_o
);
  logic [7:0] last_reg = 8'h5A;
  // outside a read the bus shows a changing pattern, never the last byte
  always_comb begin
    if (rd_i) begin
      byte_o = addr_i[0] ? (addr_i[16:9] ^ 8'hA5) : addr_i[8:1];
    end else begin
      byte_o = ~last_reg;
    end
  end
  always @(posedge clk_i) begin
    last_reg <= byte_o;
  end
endmodule
`default_nettype wire

// ===== testbench/table_access_and_zero_skip_exec_bench.sv
`timescale 1ns/1ns
`default_nettype none
module table_access_and_zero_skip_exec_bench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        valid = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic        two_word = 1'b0;
  logic        xcfg = 1'b0;
  logic        cfg_load = 1'b0;
  logic [3:0]  bank = 4'h3;
  logic [7:0]  fsr2 = 8'h40;
  logic [7:0]  rdata = 8'h00;
  logic        ptr_wr = 1'b0;
  logic [20:0] ptr_wd = 21'h000000;
  logic        lat_wr = 1'b0;
  logic [7:0]  lat_wd = 8'h00;
  logic [11:0] reg_addr;
  logic [20:0] paddr;
  logic        prd;
  logic [7:0]  pbyte;
  logic [20:0] ptr;
  logic [7:0]  latch;
  logic [63:0] hold;
  logic [63:0] hold_exp = {64{1'b1}};
  logic        busy;
  logic        squash;
  logic        ext_set;
  int          n_mismatch = 0;
  int          tests_run = 0;
  always #5 clk = ~clk;
  tbl_skip_exec uut (.CLOCK_I(clk), .RST_N_I(rst_n), .INSTR_VALID_I(valid), .INSTR_I(instr),
    .NEXT_TWO_WORD_I(two_word), .EXT_SET_CFG_I(xcfg), .CFG_LOAD_I(cfg_load),
    .BANK_SELECT_I(bank), .FSR2_LOW_I(fsr2), .REG_DATA_I(rdata), .PROG_BYTE_I(pbyte),
    .PTR_WR_I(ptr_wr), .PTR_WDATA_I(ptr_wd), .LATCH_WR_I(lat_wr), .LATCH_WDATA_I(lat_wd),
    .REG_ADDR_O(reg_addr), .PROG_ADDR_O(paddr), .PROG_RD_O(prd), .TABLE_POINTER_O(ptr),
    .TABLE_LATCH_O(latch), .HOLD_DATA_O(hold), .BUSY_O(busy), .SQUASH_O(squash),
    .EXT_SET_ENABLE_O(ext_set));
  prog_flash_model flash (.clk_i(clk), .rd_i(prd), .addr_i(paddr), .byte_o(pbyte));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic tbl(input logic wr, input logic [1:0] m, input logic [20:0] p,
                     input logic [7:0] l);
    logic [20:0] a;
    logic [20:0] e;
    a = (m == 2'h3) ? p + 21'h1 : p;
    e = (m == 2'h1) ? a + 21'h1 : (m == 2'h2) ? a - 21'h1 : a;
    @(negedge clk);
    ptr_wr = 1'b1; ptr_wd = p; lat_wr = 1'b1; lat_wd = l;
    @(negedge clk);
    ptr_wr = 1'b0; lat_wr = 1'b0;
    instr = {12'h000, 1'b1, wr, m};
    valid = 1'b1;
    @(negedge clk);
    valid = 1'b0;
    chk(busy, 1'b1, "busy first");
    chk(prd, !wr, "read strobe");
    chk(paddr, a, "access address");
    @(negedge clk);
    chk(busy | prd, 1'b0, "strobes after");
    if (wr) begin
      hold_exp[a[2:0]*8 +: 8] = l;
      chk(hold, hold_exp, "holding");
    end else begin
      chk(latch, a[0] ? (a[16:9] ^ 8'hA5) : a[8:1], "latch");
    end
    chk(ptr, e, "pointer");
  endtask
  task automatic skip(input logic [15:0] op, input logic [7:0] d, input logic tw,
                      input logic [11:0] ea, input logic [11:0] mask, input int n);
    @(negedge clk);
    instr = op; rdata = d; valid = 1'b1;
    @(negedge clk);
    valid = 1'b0; two_word = tw;
    chk(reg_addr & mask, ea, "file address");
    chk(squash, n > 0, "squash first");
    @(negedge clk);
    two_word = 1'b0;
    chk(squash, n > 1, "squash second");
    @(negedge clk);
    chk(squash, 1'b0, "squash end");
  endtask
  task automatic t_reset;
    chk({ptr, latch}, 29'h0, "pointer and latch reset");
    chk(hold, {64{1'b1}}, "holding reset");
    chk({ext_set, busy, squash, prd}, 4'h8, "flag reset");
    $display("test reset done");
  endtask
  task automatic t_table;
    for (int m = 0; m < 4; m++) begin
      tbl(1'b0, m[1:0], 21'h00A356 + 21'(m), 8'h55);
      tbl(1'b1, m[1:0], 21'h01389A + 21'(m), 8'h30 + m[7:0]);
    end
    tbl(1'b0, 2'h1, 21'h1FFFFF, 8'h00);
    tbl(1'b0, 2'h2, 21'h000000, 8'h00);
    tbl(1'b1, 2'h0, 21'h1FFFFF, 8'hC3);
    $display("test table done");
  endtask
  task automatic t_skip;
    skip(16'h6712, 8'h00, 1'b0, 12'h312, 12'hFFF, 1);
    skip(16'h6680, 8'h00, 1'b1, 12'hF80, 12'hFFF, 2);
    skip(16'h6630, 8'h01, 1'b1, 12'h070, 12'hFFF, 0);
    skip(16'h665F, 8'h00, 1'b0, 12'h09F, 12'hFFF, 1);
    skip(16'h6660, 8'h00, 1'b0, 12'hF60, 12'hFFF, 1);
    $display("test skip done");
  endtask
  task automatic t_config;
    @(negedge clk);
    cfg_load = 1'b1;
    @(negedge clk);
    cfg_load = 1'b0; xcfg = 1'b1;
    chk(ext_set, 1'b0, "config captured");
    @(negedge clk);
    cfg_load = 1'b1;
    @(negedge clk);
    cfg_load = 1'b0;
    chk(ext_set, 1'b0, "config held");
    skip(16'h6630, 8'h00, 1'b0, 12'h030, 12'hFFF, 1);
    $display("test config done");
  endtask
  // pointer load and a repeated instruction both arrive while a table op is busy
  task automatic t_refuse;
    @(negedge clk);
    ptr_wr = 1'b1; ptr_wd = 21'h000100;
    @(negedge clk);
    ptr_wd = 21'h0ABCDE; instr = 16'h0009; valid = 1'b1;
    @(negedge clk);
    chk(paddr, 21'h000100, "load lost to table op");
    chk(ptr, 21'h000100, "pointer held in decode");
    @(negedge clk);
    ptr_wr = 1'b0; valid = 1'b0;
    chk(busy, 1'b0, "second cycle instruction ignored");
    chk(ptr, 21'h000101, "pointer after refused load");
    $display("test refuse done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // whole run is about 80 cycles; this leaves wide margin
  initial begin
    #20000;
    n_mismatch++;
    test_done();
  end
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_table();
    t_skip();
    t_config();
    t_refuse();
    test_done();
  end
endmodule
`default_nettype wire
